// file: flash_bus_if.sv
// Interface: cycle requests between the host sequencer and the pin engine
`timescale 1ns/1ps
interface flash_bus_if;
   logic        req;
   logic        wr;
   logic [19:0] addr;
   logic [15:0] wdata;
   logic        done;
   logic [15:0] rdata;

   modport ctl (output req, output wr, output addr, output wdata, input done, input rdata);
   modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : flash_bus_if

// file: flash_cycle_engine.sv
// Pin engine: one write or read cycle on the flash chip-enable bus
`timescale 1ns/1ps
module flash_cycle_engine
   import flash_host_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   flash_bus_if.eng         bus,
   output logic [19:0]      flash_addr,
   output logic             flash_ce_b,
   output logic             flash_oe_b,
   output logic             flash_we_b,
   input  wire logic [15:0] flash_dq_in,
   output logic [15:0]      flash_dq_out,
   output logic             flash_dq_oe
);

   eng_s q;
   eng_s d;

   always_comb begin
      d       = q;
      d.done  = 1'b0;
      d.sync1 = flash_dq_in;
      d.sync2 = q.sync1;
      case (q.st)
         E_IDLE: begin
            if (bus.req) begin
               d.addr  = bus.addr;
               d.wdata = bus.wdata;
               d.wr    = bus.wr;
               d.cnt   = 3'h0;
               d.ce_b  = 1'b0;
               d.we_b  = ~bus.wr;
               d.oe_b  = bus.wr;
               d.dq_oe = bus.wr;
               d.st    = E_ACT;
            end
         end
         E_ACT: begin
            d.cnt = q.cnt + 3'h1;
            if (q.wr) begin
               d.we_b = 1'b1;
               d.st   = E_HOLD;
            end else if (q.cnt == RD_LAST) begin
               d.rdata = q.sync2;
               d.ce_b  = 1'b1;
               d.oe_b  = 1'b1;
               d.done  = 1'b1;
               d.st    = E_IDLE;
            end
         end
         E_HOLD: begin
            d.ce_b  = 1'b1;
            d.dq_oe = 1'b0;
            d.done  = 1'b1;
            d.st    = E_IDLE;
         end
         default: begin
            d = ENG_RESET;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         q <= ENG_RESET;
      end else begin
         q <= d;
      end
   end

   assign bus.done     = q.done;
   assign bus.rdata    = q.rdata;
   assign flash_addr   = q.addr;
   assign flash_ce_b   = q.ce_b;
   assign flash_oe_b   = q.oe_b;
   assign flash_we_b   = q.we_b;
   assign flash_dq_out = q.wdata;
   assign flash_dq_oe  = q.dq_oe;

endmodule : flash_cycle_engine

// file: flash_device_model.sv
// Partner model: flash status register and array reads
`timescale 1ns/1ps
module flash_device_model
   import flash_host_pkg::*;
(
   input  wire logic [19:0] flash_addr,
   input  wire logic        flash_ce_b,
   input  wire logic        flash_oe_b,
   input  wire logic        flash_we_b,
   input  wire logic        flash_reset_b,
   input  wire logic [15:0] flash_dq_out,
   input  wire logic [7:0]  engine_state,
   output logic [15:0]      flash_dq_in
);
   logic [7:0]  sticky_q = 8'h00;
   logic        status_mode_q = 1'b0;
   logic [15:0] snap_q = 16'h0000;
   logic [7:0]  status_word;
   // Engine flags live, error flags sticky, bit zero reserved
   assign status_word = {engine_state[7:6],
                         engine_state[5:3] | sticky_q[5:3],
                         engine_state[2],
                         engine_state[1] | sticky_q[1],
                         1'b0};
   always @(engine_state) begin
      sticky_q = sticky_q | (engine_state & 8'h3A);
   end
   always @(posedge flash_we_b or negedge flash_reset_b) begin
      if (!flash_reset_b) begin
         sticky_q = 8'h00;
         status_mode_q = 1'b0;
      end else if (!flash_ce_b) begin
         status_mode_q = (flash_dq_out[7:0] == CMD_READ_STATUS);
         if (flash_dq_out[7:0] == CMD_CLEAR_STATUS) begin
            sticky_q = 8'h00;
         end
      end
   end
   // Snapshot at the later enable fall
   always @(negedge (flash_ce_b | flash_oe_b)) begin
      snap_q = status_mode_q ? {8'h00, status_word} : (flash_addr[15:0] ^ 16'h5A3C);
   end
   assign flash_dq_in = (!flash_ce_b && !flash_oe_b && flash_reset_b) ? snap_q : ~snap_q;
endmodule : flash_device_model

// file: flash_host_pkg.sv
// Package: constants, commands, register map and state types of the status host
package flash_host_pkg;

   // Register offsets, byte addresses on the order port
   localparam logic [7:0] REG_ADDR_OFS   = 8'h00;
   localparam logic [7:0] REG_CMD_OFS    = 8'h04;
   localparam logic [7:0] REG_CTRL_OFS   = 8'h08;
   localparam logic [7:0] REG_STATUS_OFS = 8'h0C;
   localparam logic [7:0] REG_DATA_OFS   = 8'h10;
   localparam logic [7:0] REG_CONFIG_OFS = 8'h14;

   // Control and config register bit positions
   localparam int CTRL_POLL_BIT  = 0;
   localparam int CTRL_CLEAR_BIT = 1;
   localparam int CTRL_READ_BIT  = 2;
   localparam int CONFIG_HOLD_RESET_BIT = 0;

   // Status word bit positions
   localparam int ENGINE_READY_BIT  = 7;
   localparam int ERASE_PAUSED_BIT  = 6;
   localparam int ERASE_FAIL_BIT    = 5;
   localparam int PROGRAM_FAIL_BIT  = 4;
   localparam int SUPPLY_LOW_BIT    = 3;
   localparam int PROGRAM_PAUSED_BIT = 2;
   localparam int LOCKED_SECTOR_BIT = 1;
   localparam int RESERVED_BIT      = 0;
   localparam logic [7:0] RESULT_BITS_MASK = 8'h3A;
   localparam logic [7:0] SEQ_ERROR_BITS   = 8'h3A;
   localparam logic [7:0] RESERVED_MASK    = 8'hFE;

   // Host status register extra bit positions
   localparam int HST_BUSY_BIT        = 8;
   localparam int HST_READY_SEEN_BIT  = 9;
   localparam int HST_SEQ_ERROR_BIT   = 10;
   localparam int HST_UPPER_FAULT_BIT = 11;
   localparam int HST_ARRAY_MODE_BIT  = 12;

   // Command codes written on the low data byte
   localparam logic [7:0] CMD_ARRAY_READ   = 8'hFF;
   localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

   // Pin timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_ACCESS_NS   = 70;
   localparam int ACC_CYCLES    = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STAGES   = 2;
   localparam logic [2:0] RD_LAST = 3'(ACC_CYCLES + SYNC_STAGES - 1);

   typedef enum logic [1:0] {E_IDLE, E_ACT, E_HOLD} eng_e;

   typedef struct packed {
      eng_e        st;
      logic [2:0]  cnt;
      logic        wr;
      logic        ce_b;
      logic        oe_b;
      logic        we_b;
      logic        dq_oe;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [15:0] sync1;
      logic [15:0] sync2;
      logic [15:0] rdata;
      logic        done;
   } eng_s;

   localparam eng_s ENG_RESET = '{st: E_IDLE, cnt: 3'h0, wr: 1'b0, ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1,
                                  dq_oe: 1'b0, addr: 20'h00000, wdata: 16'h0000, sync1: 16'h0000,
                                  sync2: 16'h0000, rdata: 16'h0000, done: 1'b0};

   typedef enum logic [2:0] {S_IDLE, S_WAIT_WR, S_POLL_CMD, S_POLL_READ, S_ARRAY_CMD, S_ARRAY_READ} host_e;

   typedef struct packed {
      host_e       st;
      logic [31:0] reg_rdata;
      logic [19:0] addr;
      logic [7:0]  status;
      logic [15:0] rdata;
      logic        req;
      logic        wr;
      logic [19:0] bus_addr;
      logic [15:0] bus_wdata;
      logic        array_mode;
      logic        ready_seen;
      logic        upper_fault;
      logic        hold_reset;
   } host_s;

   localparam host_s HOST_RESET = '{st: S_IDLE, reg_rdata: 32'h00000000, addr: 20'h00000, status: 8'h00,
                                    rdata: 16'h0000, req: 1'b0, wr: 1'b0, bus_addr: 20'h00000,
                                    bus_wdata: 16'h0000, array_mode: 1'b1, ready_seen: 1'b0,
                                    upper_fault: 1'b0, hold_reset: 1'b0};

   // Result bits count only once the engine reports ready
   function automatic logic [7:0] status_view(input logic [7:0] s);
      status_view = s[ENGINE_READY_BIT] ? (s & RESERVED_MASK) : (s & RESERVED_MASK & ~RESULT_BITS_MASK);
   endfunction : status_view

   function automatic logic seq_error(input logic [7:0] s);
      seq_error = ((status_view(s) & SEQ_ERROR_BITS) == SEQ_ERROR_BITS);
   endfunction : seq_error

endpackage : flash_host_pkg

// file: flash_host_properties.sv
// Checker: pin and register port timing of the status host
`timescale 1ns/1ps
module flash_host_properties
   import flash_host_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [19:0] flash_addr,
   input wire logic        flash_ce_b,
   input wire logic        flash_oe_b,
   input wire logic        flash_we_b,
   input wire logic        flash_reset_b,
   input wire logic [15:0] flash_dq_in,
   input wire logic [15:0] flash_dq_out,
   input wire logic        flash_dq_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence read_strobe_s;
      !flash_oe_b [*3] ##1 flash_oe_b;
   endsequence
   sequence write_strobe_s;
      flash_we_b ##1 flash_ce_b;
   endsequence
   read_len_a: assert property ($fell(flash_oe_b) |-> read_strobe_s)
      else $error("read strobe length wrong");
   write_len_a: assert property ($fell(flash_we_b) |=> write_strobe_s)
      else $error("write strobe length wrong");
   enable_toggle_a: assert property ($fell(flash_oe_b) |-> $past(flash_ce_b) && !flash_ce_b)
      else $error("read without enable toggle");
   we_in_ce_a: assert property (!flash_we_b |-> !flash_ce_b && flash_oe_b)
      else $error("write strobe outside chip enable");
   no_contend_a: assert property (flash_dq_oe |-> flash_oe_b)
      else $error("data driven during read");
   cmd_upper_a: assert property ($fell(flash_we_b) |-> flash_dq_oe && flash_dq_out[15:8] == 8'h00)
      else $error("command upper byte not zero");
   addr_hold_a: assert property (!flash_ce_b && !$fell(flash_ce_b) |-> $stable(flash_addr))
      else $error("address moved in cycle");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
      else $error("read data outside answer cycle");
   reset_pin_a: assert property ($fell(flash_reset_b) |-> $past(reg_wr) &&
                                 $past(reg_addr) == REG_CONFIG_OFS)
      else $error("flash reset without config write");
endmodule : flash_host_properties

bind flash_status_host flash_host_properties chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
   .flash_ce_b(flash_ce_b), .flash_oe_b(flash_oe_b), .flash_we_b(flash_we_b), .flash_reset_b(flash_reset_b),
   .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));

// file: flash_status_host.sv
// Host controller: issues flash commands and polls the flash status word
`timescale 1ns/1ps
module flash_status_host
   import flash_host_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   output logic [19:0]      flash_addr,
   output logic             flash_ce_b,
   output logic             flash_oe_b,
   output logic             flash_we_b,
   output logic             flash_reset_b,
   input  wire logic [15:0] flash_dq_in,
   output logic [15:0]      flash_dq_out,
   output logic             flash_dq_oe
);

   flash_bus_if bus ();

   host_s q;
   host_s d;

   // Pin engine
   flash_cycle_engine u_engine (
      .clk          (clk),
      .rst_b        (rst_b),
      .bus          (bus.eng),
      .flash_addr   (flash_addr),
      .flash_ce_b   (flash_ce_b),
      .flash_oe_b   (flash_oe_b),
      .flash_we_b   (flash_we_b),
      .flash_dq_in  (flash_dq_in),
      .flash_dq_out (flash_dq_out),
      .flash_dq_oe  (flash_dq_oe)
   );

   always_comb begin
      d           = q;
      d.req       = 1'b0;
      d.reg_rdata = 32'h00000000;

      // Register reads, data in the following cycle
      if (reg_rd) begin
         case (reg_addr)
            REG_ADDR_OFS: begin
               d.reg_rdata = {12'h000, q.addr};
            end
            REG_STATUS_OFS: begin
               d.reg_rdata[7:0]                = status_view(q.status);
               d.reg_rdata[HST_BUSY_BIT]        = (q.st != S_IDLE);
               d.reg_rdata[HST_READY_SEEN_BIT]  = q.ready_seen;
               d.reg_rdata[HST_SEQ_ERROR_BIT]   = seq_error(q.status);
               d.reg_rdata[HST_UPPER_FAULT_BIT] = q.upper_fault;
               d.reg_rdata[HST_ARRAY_MODE_BIT]  = q.array_mode;
            end
            REG_DATA_OFS: begin
               d.reg_rdata = {16'h0000, q.rdata};
            end
            REG_CONFIG_OFS: begin
               d.reg_rdata = {31'h0, q.hold_reset};
            end
            default: begin
               d.reg_rdata = 32'h00000000;
            end
         endcase
      end

      // Address and config writes accepted in any state
      if (reg_wr && reg_addr == REG_ADDR_OFS) begin
         d.addr = reg_wdata[19:0];
      end
      if (reg_wr && reg_addr == REG_CONFIG_OFS) begin
         d.hold_reset = reg_wdata[CONFIG_HOLD_RESET_BIT];
         if (reg_wdata[CONFIG_HOLD_RESET_BIT]) begin
            d.status     = 8'h00;
            d.ready_seen = 1'b0;
            d.array_mode = 1'b1;
         end
      end

      // Flash cycle sequencing
      case (q.st)
         S_IDLE: begin
            if (reg_wr && reg_addr == REG_CMD_OFS) begin
               // Raw command byte
               d.req        = 1'b1;
               d.wr         = 1'b1;
               d.bus_addr   = q.addr;
               d.bus_wdata  = {8'h00, reg_wdata[7:0]};
               d.array_mode = (reg_wdata[7:0] == CMD_ARRAY_READ);
               d.st         = S_WAIT_WR;
            end else if (reg_wr && reg_addr == REG_CTRL_OFS) begin
               if (reg_wdata[CTRL_POLL_BIT]) begin
                  // Status poll
                  d.req       = 1'b1;
                  d.wr        = 1'b1;
                  d.bus_addr  = q.addr;
                  d.bus_wdata = {8'h00, CMD_READ_STATUS};
                  d.st        = S_POLL_CMD;
               end else if (reg_wdata[CTRL_CLEAR_BIT]) begin
                  // Clear cached result bits
                  d.req        = 1'b1;
                  d.wr         = 1'b1;
                  d.bus_addr   = q.addr;
                  d.bus_wdata  = {8'h00, CMD_CLEAR_STATUS};
                  d.status     = q.status & ~RESULT_BITS_MASK;
                  d.array_mode = 1'b0;
                  d.st         = S_WAIT_WR;
               end else if (reg_wdata[CTRL_READ_BIT]) begin
                  // Array read, command first outside array mode
                  d.req      = 1'b1;
                  d.bus_addr = q.addr;
                  if (q.array_mode) begin
                     d.wr = 1'b0;
                     d.st = S_ARRAY_READ;
                  end else begin
                     d.wr        = 1'b1;
                     d.bus_wdata = {8'h00, CMD_ARRAY_READ};
                     d.st        = S_ARRAY_CMD;
                  end
               end
            end
         end

         S_WAIT_WR: begin
            if (bus.done) begin
               d.st = S_IDLE;
            end
         end

         S_POLL_CMD: begin
            if (bus.done) begin
               // Status mode entered, start reading
               d.array_mode = 1'b0;
               d.req        = 1'b1;
               d.wr         = 1'b0;
               d.st         = S_POLL_READ;
            end
         end

         S_POLL_READ: begin
            if (bus.done) begin
               d.status      = bus.rdata[7:0];
               d.upper_fault = q.upper_fault | (bus.rdata[15:8] != 8'h00);
               if (bus.rdata[ENGINE_READY_BIT]) begin
                  // Ready seen, stop polling
                  d.ready_seen = 1'b1;
                  d.st         = S_IDLE;
               end else begin
                  // Enables toggle before the next read
                  d.ready_seen = 1'b0;
                  d.req        = 1'b1;
                  d.wr         = 1'b0;
               end
            end
         end

         S_ARRAY_CMD: begin
            if (bus.done) begin
               // Array mode entered, now read
               d.array_mode = 1'b1;
               d.req        = 1'b1;
               d.wr         = 1'b0;
               d.st         = S_ARRAY_READ;
            end
         end

         S_ARRAY_READ: begin
            if (bus.done) begin
               d.rdata = bus.rdata;
               d.st    = S_IDLE;
            end
         end

         default: begin
            d.st = S_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         q <= HOST_RESET;
      end else begin
         q <= d;
      end
   end

   // Requests to the pin engine and pin outputs
   assign bus.req       = q.req;
   assign bus.wr        = q.wr;
   assign bus.addr      = q.bus_addr;
   assign bus.wdata     = q.bus_wdata;
   assign reg_rdata     = q.reg_rdata;
   assign flash_reset_b = ~q.hold_reset;

endmodule : flash_status_host

// file: tb.sv
// Testbench: register port stimulus, flash model and result checks
`timescale 1ns/1ps
module tb;
   import flash_host_pkg::*;
   logic        clk, rst_b, reg_wr, reg_rd, rd_q;
   logic        flash_ce_b, flash_oe_b, flash_we_b, flash_reset_b, flash_dq_oe;
   logic [7:0]  reg_addr, engine_state, sticky;
   logic [19:0] flash_addr;
   logic [15:0] flash_dq_in, flash_dq_out;
   logic [31:0] reg_wdata, reg_rdata, rnd;
   logic [31:0] exp_q[$], mask_q[$];
   logic [7:0]  tbl[10] = '{8'h80, 8'hC0, 8'h84, 8'hA0, 8'h90, 8'h80, 8'h88, 8'h82, 8'hBB, 8'h80};
   int          n_mismatch = 0, checks = 0, cycles = 0;

   flash_status_host uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_ce_b(flash_ce_b),
      .flash_oe_b(flash_oe_b), .flash_we_b(flash_we_b), .flash_reset_b(flash_reset_b),
      .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
   flash_device_model dev (.flash_addr(flash_addr), .flash_ce_b(flash_ce_b), .flash_oe_b(flash_oe_b),
      .flash_we_b(flash_we_b), .flash_reset_b(flash_reset_b), .flash_dq_out(flash_dq_out),
      .engine_state(engine_state), .flash_dq_in(flash_dq_in));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic print_verdict();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : print_verdict

   task automatic compare(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
      checks++;
      if ((got & m) !== (e & m)) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask : compare

   // Answer checker: oldest note against the data cycle
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         print_verdict();
      end else begin
         rd_q <= reg_rd;
         if (rd_q && exp_q.size() > 0) compare(reg_rdata, exp_q.pop_front(), mask_q.pop_front());
      end
   end

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      mask_q.push_back(m);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask : reg_read

   task automatic wait_idle();
      repeat (2) @(posedge clk);
      for (int i = 0; i < 300; i++) begin
         reg_read(REG_STATUS_OFS, 32'h0, 32'h0);
         if (reg_rdata[HST_BUSY_BIT] === 1'b0) break;
         if (i == 299) n_mismatch++;
      end
   endtask : wait_idle

   function automatic logic [31:0] exp_status(input logic [7:0] v);
      return {21'h0, sticky == 8'h3A, 2'b10, v[7:6], sticky[5:3], v[2], sticky[1], 1'b0};
   endfunction : exp_status

   // Busy first, then ready with the given flags
   task automatic poll(input logic [7:0] v);
      engine_state <= {1'b0, v[6:0]};
      reg_write(REG_CTRL_OFS, 32'h1);
      repeat (20) @(posedge clk);
      engine_state <= v | 8'h80;
      wait_idle();
      sticky = sticky | (v & 8'h3A);
      reg_read(REG_STATUS_OFS, exp_status(v), 32'h1FFF);
   endtask : poll

   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rd_q = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      engine_state = 8'h80;
      sticky = 8'h00;
      rnd = $urandom(78);
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      reg_read(REG_STATUS_OFS, 32'h1000, 32'hFFFFFFFF);
      reg_read(8'h3C, 32'h0, 32'hFFFFFFFF);
      reg_write(REG_ADDR_OFS, {12'h0, rnd[19:0]});
      foreach (tbl[i]) begin
         if (i == 8) begin
            reg_write(REG_CTRL_OFS, 32'h2);
            wait_idle();
            sticky = 8'h00;
         end
         poll(tbl[i]);
      end
      for (int i = 0; i < 4; i++) begin
         rnd = $urandom();
         poll({1'b1, rnd[6:0]});
      end
      reg_write(REG_ADDR_OFS, {12'h0, rnd[31:12]});
      reg_write(REG_CTRL_OFS, 32'h4);
      wait_idle();
      reg_read(REG_DATA_OFS, {16'h0, rnd[27:12] ^ 16'h5A3C}, 32'hFFFFFFFF);
      reg_read(REG_STATUS_OFS, 32'h1000, 32'h1000);
      poll(8'hB2);
      reg_write(REG_CONFIG_OFS, 32'h1);
      repeat (3) @(posedge clk);
      reg_read(REG_CONFIG_OFS, 32'h1, 32'hFFFFFFFF);
      reg_write(REG_CONFIG_OFS, 32'h0);
      sticky = 8'h00;
      poll(8'h80);
      repeat (5) @(posedge clk);
      print_verdict();
   end
endmodule : tb
